/* disk_write_pkg.sv */
package disk_write_pkg;
  // ************************************************************
  // sizes
  // ************************************************************
  localparam int sel_width = 6;
  localparam int group_width = 3;
  localparam int channel_count = 64;
  localparam int group_size = 8;
  localparam int board_count = 3;
  localparam int ff_per_board = 3;
  localparam int info_ff_count = 2;
  localparam int loop_count = board_count * ff_per_board - info_ff_count;
  localparam int target_width = 3;
  localparam int fifo_depth = 16;

  // ************************************************************
  // field positions and reset values
  // ************************************************************
  localparam int horiz_lsb = 0;
  localparam int vert_lsb = 3;
  localparam logic [target_width-1:0] target_info = 3'h0;
  localparam logic [sel_width-1:0] sel_reset = 6'h00;
  localparam logic info_ff_reset = 1'h1;
  localparam logic loop_ff_reset = 1'h0;

  // ************************************************************
  // types
  // ************************************************************
  typedef enum logic [1:0] {
    cmd_not_write,
    cmd_write_zero,
    cmd_write_one
  } write_cmd_type;

  // target 0 is the information channel path, 1..7 the loop and register amplifiers
  typedef struct packed {
    logic [target_width-1:0] target;
    logic [sel_width-1:0] channel;
    write_cmd_type cmd;
  } write_req_type;

  localparam int req_width = $bits(write_req_type);

  typedef struct packed {
    logic info_write_ff_zero;
    logic info_write_ff_one;
  } info_pair_type;
endpackage

/* disk_write_channel_select.sv */
// Operation
// - each of 64 selector codes gates one switch
// - octal channel number equals selector bits, bit one lowest
// - at most one channel head records
// - gate needs both horizontal and vertical group decode
// - loop amplifier accepts only write one, write zero
// - write zero sets loop flip-flop to zero
// - write one sets loop flip-flop to one
// - channel path has three commands in flip-flop pair
// - pair 11 idle, 10 write one, 01 write zero
// - flip-flop one state gives no head current
// - channel current only while some switch gated
// - first flip-flop current records zero bit
// - second flip-flop current records one bit
// - nine amplifier flip-flops, two shared by channels

// ************************************************************
// command fifo
// ************************************************************
module write_cmd_fifo #(
  parameter int width = 8,
  parameter int depth = 16
) (
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [width-1:0] i_data,
  output logic o_valid,
  input wire logic i_ready,
  output logic [width-1:0] o_data
);
  localparam int aw = $clog2(depth);

  logic [width-1:0] mem [depth];
  logic [aw-1:0] wr_ptr;
  logic [aw-1:0] rd_ptr;
  logic [aw:0] count;
  logic push;
  logic pop;
  logic full;
  logic empty;
  logic [aw:0] next_count;

  // ************************************************************
  // flags and handshake
  // ************************************************************
  assign full = (count == (aw+1)'(depth));
  assign empty = (count == '0);
  assign o_ready = !full;
  assign o_valid = !empty;
  assign push = i_valid && o_ready;
  assign pop = o_valid && i_ready;
  assign o_data = mem[rd_ptr];

  // ************************************************************
  // storage
  // ************************************************************
  // storage has no reset; only words behind a valid count are ever read
  always_ff @(posedge i_ref_clk) begin
    if (push) begin
      mem[wr_ptr] <= i_data;
    end
  end

  // ************************************************************
  // pointers
  // ************************************************************
  // wrap by compare, so a depth that is not a power of two still works
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wr_ptr <= '0;
    end else if (push) begin
      wr_ptr <= (wr_ptr == aw'(depth - 1)) ? '0 : aw'(wr_ptr + 1'b1);
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rd_ptr <= '0;
    end else if (pop) begin
      rd_ptr <= (rd_ptr == aw'(depth - 1)) ? '0 : aw'(rd_ptr + 1'b1);
    end
  end

  // ************************************************************
  // occupancy
  // ************************************************************
  always_comb begin
    next_count = count;
    if (push && !pop) begin
      next_count = (aw+1)'(count + 1'b1);
    end else if (pop && !push) begin
      next_count = (aw+1)'(count - 1'b1);
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end
endmodule

// ************************************************************
// write path top
// ************************************************************
module disk_write_channel_select #(
  parameter int fifo_depth = disk_write_pkg::fifo_depth
) (
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  input wire logic i_bit_clk,
  input wire logic i_write_enable,
  input wire logic i_req_valid,
  output logic o_req_ready,
  input wire disk_write_pkg::write_req_type i_req,
  output logic [disk_write_pkg::channel_count-1:0] o_head_gate,
  output logic o_info_zero_current,
  output logic o_info_one_current,
  output disk_write_pkg::info_pair_type o_info_pair,
  output logic [disk_write_pkg::sel_width-1:0] o_channel_sel,
  output logic [disk_write_pkg::loop_count-1:0] o_loop_write_one,
  output logic [disk_write_pkg::loop_count-1:0] o_loop_write_zero,
  output logic o_busy
);
  // ************************************************************
  // decode helpers
  // ************************************************************
  function automatic logic [disk_write_pkg::group_size-1:0] group_decode(
    input logic [disk_write_pkg::group_width-1:0] code
  );
    logic [disk_write_pkg::group_size-1:0] hot;
    hot = '0;
    hot[code] = 1'b1;
    return hot;
  endfunction

  function automatic logic targets_info(
    input disk_write_pkg::write_req_type req
  );
    return req.target == disk_write_pkg::target_info;
  endfunction

  function automatic logic targets_loop(
    input disk_write_pkg::write_req_type req,
    input int unsigned idx
  );
    // loop amplifier idx answers to target idx plus one
    return req.target == disk_write_pkg::target_width'(idx + 1);
  endfunction

  // a side drives only while it sits at zero and its partner at one
  function automatic logic side_drives(
    input logic own,
    input logic partner
  );
    return !own && partner;
  endfunction

  // ************************************************************
  // state
  // ************************************************************
  disk_write_pkg::write_req_type head_req;
  logic head_valid;
  logic apply;
  logic applied_this_half;
  logic info_apply;
  logic [disk_write_pkg::loop_count-1:0] loop_apply;
  logic [disk_write_pkg::sel_width-1:0] channel_sel;
  disk_write_pkg::info_pair_type info_pair;
  logic [disk_write_pkg::loop_count-1:0] loop_ff;
  logic [disk_write_pkg::group_size-1:0] horiz_bus;
  logic [disk_write_pkg::group_size-1:0] vert_bus;
  logic [disk_write_pkg::channel_count-1:0] next_gate;
  logic gate_any;
  logic [disk_write_pkg::channel_count-1:0] head_gate;
  logic zero_current;
  logic one_current;

  // ************************************************************
  // command queue
  // ************************************************************
  write_cmd_fifo #(
    .width(disk_write_pkg::req_width),
    .depth(fifo_depth)
  ) u_fifo (
    .i_ref_clk(i_ref_clk),
    .i_arst_n(i_arst_n),
    .i_valid(i_req_valid),
    .o_ready(o_req_ready),
    .i_data(i_req),
    .o_valid(head_valid),
    .i_ready(apply),
    .o_data(head_req)
  );

  // ************************************************************
  // command timing
  // ************************************************************
  // one command per false half; a burst simply backs up in the fifo
  assign apply = head_valid && !i_bit_clk && !applied_this_half;
  assign info_apply = apply && targets_info(head_req);

  // ************************************************************
  // one command per false half
  // ************************************************************
  // cleared on every true cycle, so each false half gets a fresh slot
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      applied_this_half <= 1'b0;
    end else if (i_bit_clk) begin
      applied_this_half <= 1'b0;
    end else if (apply) begin
      applied_this_half <= 1'b1;
    end
  end

  // ************************************************************
  // channel selector
  // ************************************************************
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      channel_sel <= disk_write_pkg::sel_reset;
    end else if (info_apply) begin
      channel_sel <= head_req.channel;
    end
  end

  // ************************************************************
  // information channel flip-flop pair
  // ************************************************************
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      info_pair <= '{info_write_ff_zero: disk_write_pkg::info_ff_reset,
                     info_write_ff_one: disk_write_pkg::info_ff_reset};
    end else if (info_apply) begin
      unique case (head_req.cmd)
        disk_write_pkg::cmd_write_one: info_pair <= '{info_write_ff_zero: 1'b1, info_write_ff_one: 1'b0};
        disk_write_pkg::cmd_write_zero: info_pair <= '{info_write_ff_zero: 1'b0, info_write_ff_one: 1'b1};
        // 00 is never produced here, so the pair stays legal
        default: info_pair <= '{info_write_ff_zero: 1'b1, info_write_ff_one: 1'b1};
      endcase
    end
  end

  // ************************************************************
  // loop and register amplifiers
  // ************************************************************
  // nine flip-flops on three boards: two above, the rest here
  generate
    for (genvar g = 0; g < disk_write_pkg::loop_count; g++) begin : g_loop
      assign loop_apply[g] = apply && targets_loop(head_req, g);

      always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
          loop_ff[g] <= disk_write_pkg::loop_ff_reset;
        end else if (loop_apply[g]) begin
          // not write has no meaning on a one flip-flop path and is dropped
          if (head_req.cmd == disk_write_pkg::cmd_write_one) begin
            loop_ff[g] <= 1'b1;
          end else if (head_req.cmd == disk_write_pkg::cmd_write_zero) begin
            loop_ff[g] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // ************************************************************
  // selection matrix
  // ************************************************************
  assign horiz_bus = group_decode(channel_sel[disk_write_pkg::horiz_lsb +: disk_write_pkg::group_width]);
  assign vert_bus = group_decode(channel_sel[disk_write_pkg::vert_lsb +: disk_write_pkg::group_width]);

  // ************************************************************
  // junction grid
  // ************************************************************
  generate
    for (genvar v = 0; v < disk_write_pkg::group_size; v++) begin : g_vert
      for (genvar h = 0; h < disk_write_pkg::group_size; h++) begin : g_horiz
        // junction of both bus gates and write enable; one hot per bus leaves at most one junction live
        assign next_gate[v * disk_write_pkg::group_size + h] =
          i_write_enable && vert_bus[v] && horiz_bus[h];
      end
    end
  endgenerate

  // ************************************************************
  // gate register
  // ************************************************************
  // gate and current share one edge, so a head never sees a stale command
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      head_gate <= '0;
    end else begin
      head_gate <= next_gate;
    end
  end

  assign gate_any = |head_gate;

  // ************************************************************
  // head current
  // ************************************************************
  // only primed sides drive; a side also needs its partner at one, so 00 stays silent
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      zero_current <= 1'b0;
    end else begin
      zero_current <= (next_gate != '0)
                      && side_drives(info_pair.info_write_ff_zero,
                                     info_pair.info_write_ff_one);
    end
  end

  // ************************************************************
  // one side current
  // ************************************************************
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      one_current <= 1'b0;
    end else begin
      one_current <= (next_gate != '0)
                     && side_drives(info_pair.info_write_ff_one,
                                    info_pair.info_write_ff_zero);
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign o_head_gate = head_gate;
  assign o_info_zero_current = zero_current && gate_any;
  assign o_info_one_current = one_current && gate_any;
  assign o_info_pair = info_pair;
  assign o_channel_sel = channel_sel;
  assign o_loop_write_one = loop_ff;
  assign o_loop_write_zero = ~loop_ff;
  assign o_busy = head_valid;
endmodule

/* disk_write_channel_select_sva.sv */
// ************************************************************
// port checker
// ************************************************************
module disk_write_channel_select_sva #(
  parameter int fifo_depth = disk_write_pkg::fifo_depth
) (
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  input wire logic i_bit_clk,
  input wire logic i_write_enable,
  input wire logic o_req_ready,
  input wire logic [63:0] o_head_gate,
  input wire logic o_info_zero_current,
  input wire logic o_info_one_current,
  input wire disk_write_pkg::info_pair_type o_info_pair,
  input wire logic [5:0] o_channel_sel,
  input wire logic [6:0] o_loop_write_one,
  input wire logic [6:0] o_loop_write_zero,
  input wire logic o_busy
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_arst_n);
  logic [14:0] st;
  assign st = {o_info_pair, o_channel_sel, o_loop_write_one};
  a_gate_onehot: assert property ($onehot0(o_head_gate))
    else $error("head gate not one-hot");
  a_gate_decode: assert property ($past(i_arst_n) |->
    o_head_gate == ($past(i_write_enable) ? 64'h1 << $past(o_channel_sel) : 64'h0))
    else $error("head gate does not follow selector");
  a_zero_cur: assert property (o_info_zero_current |->
    (|o_head_gate) && !$past(o_info_pair.info_write_ff_zero)) else $error("bad zero current");
  a_one_cur: assert property (o_info_one_current |->
    (|o_head_gate) && !$past(o_info_pair.info_write_ff_one)) else $error("bad one current");
  a_no_both: assert property (!(o_info_zero_current && o_info_one_current))
    else $error("both head currents");
  a_loop_sides: assert property (o_loop_write_zero == ~o_loop_write_one)
    else $error("loop sides disagree");
  a_false_half: assert property (st != $past(st) |-> !$past(i_bit_clk))
    else $error("command applied in true half");
  a_one_apply: assert property (st != $past(st) |=> st == $past(st))
    else $error("two commands in one half");
  cover property (o_info_one_current);
  cover property (o_info_zero_current);
  cover property (!o_req_ready && o_busy);
endmodule

bind disk_write_channel_select disk_write_channel_select_sva #(.fifo_depth(fifo_depth)) u_sva (
  .i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n), .i_bit_clk(i_bit_clk), .i_write_enable(i_write_enable),
  .o_req_ready(o_req_ready), .o_head_gate(o_head_gate), .o_info_zero_current(o_info_zero_current),
  .o_info_one_current(o_info_one_current), .o_info_pair(o_info_pair), .o_channel_sel(o_channel_sel),
  .o_loop_write_one(o_loop_write_one), .o_loop_write_zero(o_loop_write_zero), .o_busy(o_busy));

/* disk_head_model.sv */
// ************************************************************
// head model, last bit per channel track
// ************************************************************
module disk_head_model (
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  input wire logic [63:0] i_head_gate,
  input wire logic i_zero_current,
  input wire logic i_one_current,
  output logic [63:0] o_track_bit,
  output logic o_fault
);
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_track_bit <= '0;
      o_fault <= 1'b0;
    end else begin
      for (int i = 0; i < 64; i++) begin
        if (i_head_gate[i] && i_zero_current) o_track_bit[i] <= 1'b0;
        if (i_head_gate[i] && i_one_current) o_track_bit[i] <= 1'b1;
      end
      // current with no gated switch has no path
      if ((i_zero_current || i_one_current) && !(|i_head_gate)) o_fault <= 1'b1;
      if (!$onehot0(i_head_gate) || (i_zero_current && i_one_current)) o_fault <= 1'b1;
    end
  end
endmodule

/* disk_write_channel_select_tb.sv */
module disk_write_channel_select_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_ref_clk = 1'b0;
  logic i_arst_n = 1'b0;
  logic i_bit_clk = 1'b1;
  logic i_write_enable = 1'b1;
  logic i_req_valid = 1'b0;
  logic hold = 1'b0;
  disk_write_pkg::write_req_type i_req = '0;
  logic o_req_ready, o_info_zero_current, o_info_one_current, o_busy, fault;
  logic [63:0] o_head_gate, track;
  disk_write_pkg::info_pair_type o_info_pair;
  logic [5:0] o_channel_sel;
  logic [6:0] o_loop_write_one, o_loop_write_zero, m;
  logic [2:0] ph = 3'h0;
  int n_errors = 0;
  int n_tests = 0;
  always #2 i_ref_clk = ~i_ref_clk;
  // hold keeps the true half, so nothing is applied
  always @(posedge i_ref_clk) begin
    ph <= ph + 3'h1;
    i_bit_clk <= ph[2] | hold;
  end
  disk_write_channel_select #(.fifo_depth(16)) u_disk_write_channel_select (
    .i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n), .i_bit_clk(i_bit_clk), .i_write_enable(i_write_enable),
    .i_req_valid(i_req_valid), .o_req_ready(o_req_ready), .i_req(i_req), .o_head_gate(o_head_gate),
    .o_info_zero_current(o_info_zero_current), .o_info_one_current(o_info_one_current),
    .o_info_pair(o_info_pair), .o_channel_sel(o_channel_sel), .o_loop_write_one(o_loop_write_one),
    .o_loop_write_zero(o_loop_write_zero), .o_busy(o_busy));
  disk_head_model u_disk_head_model (.i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n), .i_head_gate(o_head_gate),
    .i_zero_current(o_info_zero_current), .i_one_current(o_info_one_current), .o_track_bit(track),
    .o_fault(fault));
  task final_report;
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task chk(input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task push(input logic [2:0] tgt, input logic [5:0] ch, input disk_write_pkg::write_cmd_type cmd);
    int n;
    @(posedge i_ref_clk);
    i_req <= '{tgt, ch, cmd};
    i_req_valid <= 1'b1;
    n = 0;
    @(negedge i_ref_clk);
    while (o_req_ready !== 1'b1 && n < 100) begin
      @(negedge i_ref_clk);
      n++;
    end
    if (n == 100) begin
      n_errors++;
      final_report();
    end
    @(posedge i_ref_clk);
    i_req_valid <= 1'b0;
  endtask
  task settle;
    int n;
    n = 0;
    @(negedge i_ref_clk);
    while (o_busy !== 1'b0 && n < 400) begin
      @(negedge i_ref_clk);
      n++;
    end
    if (n == 400) begin
      n_errors++;
      final_report();
    end
    repeat (3) @(negedge i_ref_clk);
  endtask
  task t_info(input logic [5:0] ch, input disk_write_pkg::write_cmd_type cmd, input logic en);
    logic one, zero;
    one = cmd == disk_write_pkg::cmd_write_one;
    zero = cmd == disk_write_pkg::cmd_write_zero;
    @(posedge i_ref_clk);
    i_write_enable <= en;
    push(3'h0, ch, cmd);
    settle();
    chk(o_channel_sel, ch);
    chk(o_info_pair, one ? 2'b10 : zero ? 2'b01 : 2'b11);
    chk(o_head_gate, en ? 64'h1 << ch : 64'h0);
    chk(o_info_zero_current, en && zero);
    chk(o_info_one_current, en && one);
    chk(o_info_pair == 2'b00, 1'b0);
  endtask
  task t_reset;
    chk(o_info_pair, 2'b11);
    chk(o_head_gate, 64'h0);
    chk({o_info_zero_current, o_info_one_current}, 2'b00);
    chk({o_loop_write_zero, o_loop_write_one}, 14'h3f80);
    chk({o_req_ready, o_busy}, 2'b10);
    $display("reset test done");
  endtask
  task t_channels;
    for (int i = 0; i < 64; i++) t_info(6'(i), disk_write_pkg::cmd_write_one, 1'b1);
    chk(track, 64'hffffffffffffffff);
    t_info(6'o43, disk_write_pkg::cmd_write_zero, 1'b1);
    chk(track, 64'hfffffff7ffffffff);
    t_info(6'o43, disk_write_pkg::cmd_not_write, 1'b1);
    t_info(6'o07, disk_write_pkg::cmd_write_zero, 1'b0);
    chk({track[7], fault}, 2'b10);
    $display("channel test done");
  endtask
  task t_loops;
    m = 7'h00;
    for (int k = 0; k < 7; k++) begin
      push(3'(k + 1), 6'h00, disk_write_pkg::cmd_write_one);
      settle();
      m[k] = 1'b1;
      chk(o_loop_write_one, m);
    end
    for (int k = 0; k < 7; k += 2) begin
      push(3'(k + 1), 6'h00, disk_write_pkg::cmd_write_zero);
      settle();
      m[k] = 1'b0;
      chk({o_loop_write_zero, o_loop_write_one}, {~m, m});
    end
    push(3'h2, 6'h00, disk_write_pkg::cmd_not_write);
    settle();
    chk(o_loop_write_one, m);
    $display("loop test done");
  endtask
  task t_fifo;
    @(posedge i_ref_clk);
    hold <= 1'b1;
    i_write_enable <= 1'b1;
    for (int i = 0; i < 16; i++) push(3'h0, 6'(i), disk_write_pkg::cmd_write_zero);
    @(negedge i_ref_clk);
    chk({o_req_ready, o_busy, o_channel_sel}, {2'b01, 6'o07});
    @(posedge i_ref_clk);
    hold <= 1'b0;
    settle();
    chk({o_channel_sel, o_head_gate[15], o_info_zero_current}, {6'h0f, 2'b11});
    chk({track[15:0], fault}, 17'h0);
    $display("fifo test done");
  endtask
  initial begin
    repeat (5) @(posedge i_ref_clk);
    i_arst_n <= 1'b1;
    @(negedge i_ref_clk);
    t_reset();
    t_channels();
    t_loops();
    t_fifo();
    final_report();
  end
endmodule
